// ===== dv/pspc_controller_props.sv
`timescale 1ns/10ps

module pspc_controller_props
  import pspc_pkg::*;
(
  input wire logic     clock,
  input wire logic     rst_b,
  input pspc_avs_req_t avsReq,
  input pspc_avs_rsp_t avsRsp,
  input pspc_pin_t     firstPulseOutput,
  input pspc_pin_t     secondPulseOutput
);
  pspc_timing_t t;
  pspc_mode_t   m;
  logic [7:0]   calm, hi, hi2, gap, per, fixLen, minLen, maxLen, lowLen;
  logic         acc, a1, a2, a1q, a2q, okHi, okHi2, okGap;

  assign acc = avsReq.write && !avsRsp.waitrequest && avsReq.byteenable[0];
  assign a1 = firstPulseOutput.oe && (firstPulseOutput.out ^ m.firstOutputPolarity);
  assign a2 = secondPulseOutput.oe && (secondPulseOutput.out ^ m.secondOutputPolarity);
  assign per = PSPC_PERIOD_MAX >> t.frequencySelect;
  assign fixLen = 8'(PSPC_FIXED_DUTY_TBL[4*t.fixedDutyField +: 4]) << (2'h3 - t.frequencySelect);
  assign minLen = 8'(PSPC_MIN_DUTY_TBL[4*t.minDutyField +: 4]) << (2'h3 - t.frequencySelect);
  assign maxLen = 8'(PSPC_MAX_DUTY_TBL[4*t.maxDutyField +: 4]) << (2'h3 - t.frequencySelect);
  assign lowLen = (minLen == 8'h00) ? 8'h01 : minLen;
  // runs that began in the first cycles after a write may be glitches of the shadow copy
  assign okHi = {1'b0, hi} + 9'd6 < {1'b0, calm};
  assign okHi2 = {1'b0, hi2} + 9'd6 < {1'b0, calm};
  assign okGap = {1'b0, gap} + 9'd6 < {1'b0, calm};

  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      {t, m, calm, hi, hi2, gap, a1q, a2q} <= '0;
    end
    else
    begin
      if (acc && avsReq.address == PSPC_ADDR_TIMING)
        t <= pspc_timing_t'(avsReq.writedata[7:0]);
      if (acc && avsReq.address == PSPC_ADDR_MODE)
        m <= pspc_mode_t'(avsReq.writedata[7:0]);
      calm <= acc ? 8'h00 : calm + 8'(calm != 8'hff);
      hi <= a1 ? hi + 8'h01 : 8'h00;
      hi2 <= a2 ? hi2 + 8'h01 : 8'h00;
      gap <= (a1 && !a1q) ? 8'h01 : gap + 8'(gap != 8'hff);
      a1q <= a1;
      a2q <= a2;
    end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  wait_one_a: assert property ((avsReq.read || avsReq.write) && avsRsp.waitrequest |=> !avsRsp.waitrequest)
    else $error("bus request not answered after one wait cycle");
  off_float_a: assert property (calm > 8'd4 && !m.generatorEnable
    |-> !firstPulseOutput.oe && !secondPulseOutput.oe)
    else $error("pin driven while generator off");
  enable_drive_a: assert property (acc && avsReq.address == PSPC_ADDR_MODE && avsReq.writedata[7]
    |-> ##[1:4] firstPulseOutput.oe)
    else $error("first pin not driven after enable");
  single_out_a: assert property (calm > 8'd4 && m.generatorEnable && !m.outputCountSelect && !m.slopeCompEnable
    |-> !secondPulseOutput.oe)
    else $error("second pin driven in single output mode");
  copy_pin_a: assert property (calm > 8'd4 && m.generatorEnable && m.outputCountSelect
    |-> secondPulseOutput.oe &&
    secondPulseOutput.out == (firstPulseOutput.out ^ m.firstOutputPolarity ^ m.secondOutputPolarity))
    else $error("second pin does not follow first pin");
  skip_width_a: assert property (okHi && a1q && !a1 && !m.outputModeSelect |-> hi == fixLen)
    else $error("skip pulse width wrong");
  period_grid_a: assert property (okGap && a1 && !a1q |-> (gap & (per - 8'h01)) == 8'h00)
    else $error("pulse not started on period boundary");
  width_limit_a: assert property (okHi && a1q && !a1 && m.outputModeSelect
    |-> hi <= maxLen && hi >= lowLen)
    else $error("width pulse outside duty limits");
  slope_len_a: assert property (okHi2 && a2q && !a2 && !m.outputCountSelect && m.slopeCompEnable
    |-> hi2 == maxLen)
    else $error("slope window length wrong");

  skip_pulse_c: cover property (okHi && a1q && !a1 && !m.outputModeSelect);
  width_pulse_c: cover property (okHi && a1q && !a1 && m.outputModeSelect);
  slope_c: cover property (okHi2 && a2q && !a2 && m.slopeCompEnable);
endmodule : pspc_controller_props

bind pspc_controller pspc_controller_props chk
(
  .clock             (clock),
  .rst_b             (rst_b),
  .avsReq            (avsReq),
  .avsRsp            (avsRsp),
  .firstPulseOutput  (firstPulseOutput),
  .secondPulseOutput (secondPulseOutput)
);

// ===== dv/pspc_power_stage.sv
`timescale 1ns/10ps

module pspc_power_stage
  import pspc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  pspc_pin_t       gatePin,
  input  wire logic       invert,
  input  wire logic [7:0] setpoint,
  input  wire logic       trip,
  output logic            cmpOne,
  output logic            cmpTwo
);
  logic [7:0] volt;
  logic       on;

  // a released pin is pulled off by the gate bias resistor; the oe bit is taken as the port direction
  assign on = gatePin.oe && (gatePin.out ^ invert);
  assign cmpOne = volt < setpoint;
  assign cmpTwo = !trip;

  // crude inductor; capped below 8'hff so that setpoint always asks for more
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      volt <= 8'h00;
    else if (on)
      volt <= (volt < 8'hc8) ? volt + 8'h01 : volt;
    else
      volt <= (volt != 8'h00) ? volt - 8'h01 : volt;
endmodule : pspc_power_stage

// ===== dv/test_pulse_skip_pwm_controller.sv
`timescale 1ns/10ps

module test_pulse_skip_pwm_controller
  import pspc_pkg::*;
;
  logic          clock = 1'b0;
  logic          rst_b = 1'b0;
  logic [7:0]    setpoint = 8'hff;
  logic          trip = 1'b0;
  logic [3:0]    be = 4'hf;
  pspc_avs_req_t req = '0;
  pspc_avs_rsp_t rsp;
  pspc_pin_t     pinOne, pinTwo;
  logic          cmpOne, cmpTwo;
  pspc_timing_t  nt;
  pspc_mode_t    m = '0;
  logic [31:0]   q;
  int            errors = 0;
  int            num_checks = 0;
  int            a1, a2, e1, o2, i, j, per;

  always #2.5 clock = ~clock;

  pspc_controller dut
  (
    .clock                  (clock),
    .rst_b                  (rst_b),
    .avsReq                 (req),
    .avsRsp                 (rsp),
    .firstComparatorResult  (cmpOne),
    .secondComparatorResult (cmpTwo),
    .firstPulseOutput       (pinOne),
    .secondPulseOutput      (pinTwo)
  );

  pspc_power_stage load
  (
    .clock    (clock),
    .rst_b    (rst_b),
    .gatePin  (pinOne),
    .invert   (m.firstOutputPolarity),
    .setpoint (setpoint),
    .trip     (trip),
    .cmpOne   (cmpOne),
    .cmpTwo   (cmpTwo)
  );

  task automatic wrap_up();
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  function automatic int duty(input logic [15:0] tbl, input logic [1:0] c, input logic [1:0] f);
    return int'(tbl[4*c +: 4]) << (3 - f);
  endfunction : duty

  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.byteenable <= be;
    req.writedata <= {24'h000000, d};
    // waitrequest and read data are both taken at the rising edge
    do
    begin
      @(posedge clock);
      n++;
    end
    while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    check(n, 2);
    @(posedge clock);
  endtask : bus

  // counts active and driven cycles of both pins over n cycles
  task automatic sample(input int n);
    a1 = 0;
    a2 = 0;
    e1 = 0;
    o2 = 0;
    repeat (n)
    begin
      @(negedge clock);
      a1 += int'(pinOne.oe && (pinOne.out ^ m.firstOutputPolarity));
      a2 += int'(pinTwo.oe && (pinTwo.out ^ m.secondOutputPolarity));
      e1 += int'(pinOne.oe);
      o2 += int'(pinTwo.oe);
    end
    @(posedge clock);
  endtask : sample

  // skip the first period after enable, then measure four whole periods
  task automatic go(input pspc_timing_t tv, input pspc_mode_t mv, input logic [7:0] sp);
    per = 128 >> tv.frequencySelect;
    m <= mv;
    setpoint <= sp;
    bus(1'b1, PSPC_ADDR_MODE, 8'h00);
    bus(1'b1, PSPC_ADDR_TIMING, tv);
    bus(1'b1, PSPC_ADDR_MODE, mv);
    repeat (per + 8) @(posedge clock);
    sample(4 * per);
  endtask : go

  initial
  begin
    #400000;
    errors++;
    wrap_up();
  end

  initial
  begin
    q = 32'($urandom(69259));
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    bus(1'b0, PSPC_ADDR_TIMING, 8'h00);
    check(q, 32'h0);
    bus(1'b0, PSPC_ADDR_MODE, 8'h00);
    check(q, 32'h0);
    sample(8);
    check(e1 + o2, 0);
    bus(1'b1, 4'hc, 8'h5a);
    bus(1'b0, 4'hc, 8'h00);
    check(q, 32'h0);
    j = int'($urandom & 32'h7f);
    bus(1'b1, PSPC_ADDR_MODE, j[7:0]);
    be = 4'he;
    bus(1'b1, PSPC_ADDR_MODE, 8'hff);
    be = 4'hf;
    bus(1'b0, PSPC_ADDR_MODE, 8'h00);
    check(q, j);
    for (i = 0; i < 4; i++)
    begin
      nt = pspc_timing_t'(8'($urandom));
      nt.frequencySelect = i[1:0];
      go(nt, {3'h4, 1'($urandom), 4'h0}, 8'hff);
      check(a1, 4 * duty(PSPC_FIXED_DUTY_TBL, nt.fixedDutyField, nt.frequencySelect));
      check(o2, 0);
    end
    go(nt, 8'h90, 8'h00);
    check(a1, 0);
    trip <= 1'b1;
    go(nt, 8'h81, 8'hff);
    check(a1, 0);
    trip <= 1'b0;
    go(nt, 8'h81, 8'hff);
    check(a1, 4 * duty(PSPC_FIXED_DUTY_TBL, nt.fixedDutyField, nt.frequencySelect));
    for (j = 0; j < 4; j++)
    begin
      nt = pspc_timing_t'(8'($urandom));
      nt.minDutyField = j[1:0];
      nt.maxDutyField = 2'(3 - j);
      go(nt, 8'h82, 8'hff);
      check(a1, 4 * duty(PSPC_MAX_DUTY_TBL, nt.maxDutyField, nt.frequencySelect));
      go(nt, 8'h82, 8'h00);
      check(a1, 4 * duty(PSPC_MIN_DUTY_TBL, nt.minDutyField, nt.frequencySelect));
    end
    go(8'h00, 8'h82, 8'hff);
    check(a1, 4 * 64);
    go(8'h00, 8'h82, 8'h00);
    check(a1, 0);
    // a period change while running is flagged, and the flag clears on a written one
    bus(1'b1, PSPC_ADDR_TIMING, 8'hc0);
    bus(1'b0, PSPC_ADDR_STATUS, 8'h00);
    check(32'(q[PSPC_STAT_FREQ_ERR]), 32'h1);
    check(32'(q[PSPC_STAT_RUNNING]), 32'h1);
    bus(1'b1, PSPC_ADDR_STATUS, 8'(1 << PSPC_STAT_FREQ_ERR));
    bus(1'b0, PSPC_ADDR_STATUS, 8'h00);
    check(32'(q[PSPC_STAT_FREQ_ERR]), 32'h0);
    go(nt, 8'hac, 8'hff);
    check(a2, a1);
    check(a1, 4 * duty(PSPC_FIXED_DUTY_TBL, nt.fixedDutyField, nt.frequencySelect));
    go(nt, 8'h84, 8'hff);
    check(a2, 4 * duty(PSPC_MAX_DUTY_TBL, nt.maxDutyField, nt.frequencySelect));
    for (i = 0; i < 6; i++)
    begin
      go(pspc_timing_t'(8'($urandom)), {2'h2, 6'($urandom)}, 8'(20 + $urandom % 100));
      check(e1, 4 * per);
    end
    bus(1'b1, PSPC_ADDR_MODE, 8'h00);
    sample(4);
    sample(8);
    check(e1 + o2, 0);
    go(nt, 8'h8a, 8'hff);
    rst_b <= 1'b0;
    sample(4);
    check(e1 + o2, 0);
    rst_b <= 1'b1;
    @(posedge clock);
    bus(1'b0, PSPC_ADDR_MODE, 8'h00);
    check(q, 32'h0);
    wrap_up();
  end
endmodule : test_pulse_skip_pwm_controller

// ===== verilog/pspc_controller.sv
`timescale 1ns/10ps

module pspc_controller
  import pspc_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  pspc_avs_req_t      avsReq,
  output pspc_avs_rsp_t      avsRsp,
  input  wire logic          firstComparatorResult,
  input  wire logic          secondComparatorResult,
  output pspc_pin_t          firstPulseOutput,
  output pspc_pin_t          secondPulseOutput
);

  typedef struct packed
  {
    pspc_timing_t timing;
    pspc_mode_t   mode;
    pspc_state_t  phase;
    logic         sampledFeedback;
    logic         skippedLast;
    logic         freqChangeError;
    logic         ack;
    logic [31:0]  readdata;
  } pspc_core_t;

  pspc_core_t            cur;
  pspc_core_t            next_cur;
  logic [PSPC_CNT_W-1:0] periodCount;
  logic                  periodStart;
  logic                  running;
  logic                  feedback;
  logic                  busReq;
  logic                  writeTake;
  logic                  pulseActive;
  logic                  slopeActive;
  logic                  firstDrive;
  logic                  secondDrive;
  logic                  secondActive;
  logic [PSPC_CNT_W-1:0] minCycles;
  logic [PSPC_CNT_W-1:0] maxCycles;
  logic [PSPC_CNT_W-1:0] fixedCycles;
  logic [31:0]           readMux;
  logic [31:0]           statusWord;
  logic                  freqErrSet;
  logic                  freqErrClear;
  pspc_timing_t          wrTiming;
  pspc_mode_t            wrMode;

  // converts a duty code to clocks at the current period length
  function automatic logic [PSPC_CNT_W-1:0] dutyCycles
  (
    input logic [15:0] tbl,
    input logic [1:0]  sel,
    input logic [1:0]  freq
  );
    logic [3:0] sixteenths;
    sixteenths = tbl[{sel, 2'b00} +: PSPC_NIBBLE];
    dutyCycles = PSPC_CNT_W'({3'h0, sixteenths} << (PSPC_DUTY_SHIFT_MAX - freq));
  endfunction : dutyCycles

  pspc_period_timer u_timer
  (
    .clock           (clock),
    .rst_b           (rst_b),
    .run             (cur.mode.generatorEnable),
    .frequencySelect (cur.timing.frequencySelect),
    .count           (periodCount),
    .running         (running),
    .periodStart     (periodStart)
  );

  // in dual input both comparators must agree for feedback; in width mode a nonzero minimum duty still starts a pulse without it
  assign feedback = firstComparatorResult &
                    (cur.mode.inputCountSelect ? secondComparatorResult : 1'b1);

  assign minCycles   = dutyCycles(PSPC_MIN_DUTY_TBL, cur.timing.minDutyField,
                                  cur.timing.frequencySelect);
  assign maxCycles   = dutyCycles(PSPC_MAX_DUTY_TBL, cur.timing.maxDutyField,
                                  cur.timing.frequencySelect);
  assign fixedCycles = dutyCycles(PSPC_FIXED_DUTY_TBL, cur.timing.fixedDutyField,
                                  cur.timing.frequencySelect);

  assign busReq             = avsReq.read | avsReq.write;
  assign avsRsp.waitrequest = busReq & ~cur.ack;
  assign avsRsp.readdata    = cur.readdata;
  assign writeTake          = avsReq.write & cur.ack & avsReq.byteenable[PSPC_LANE0];
  assign wrTiming           = avsReq.writedata[PSPC_REG_W-1:0];
  assign wrMode             = avsReq.writedata[PSPC_REG_W-1:0];

  // changing the period while running would tear the current cycle
  assign freqErrSet   = writeTake && (avsReq.address == PSPC_ADDR_TIMING) &&
                        cur.mode.generatorEnable &&
                        (wrTiming.frequencySelect != cur.timing.frequencySelect);
  assign freqErrClear = writeTake && (avsReq.address == PSPC_ADDR_STATUS) &&
                        avsReq.writedata[PSPC_STAT_FREQ_ERR];

  always_comb
  begin
    statusWord                                                = '0;
    statusWord[PSPC_STAT_PULSE]                               = (cur.phase == PSPC_ST_PULSE);
    statusWord[PSPC_STAT_FEEDBACK]                            = cur.sampledFeedback;
    statusWord[PSPC_STAT_RUNNING]                             = running;
    statusWord[PSPC_STAT_SKIPPED]                             = cur.skippedLast;
    statusWord[PSPC_STAT_FREQ_ERR]                            = cur.freqChangeError;
    statusWord[PSPC_STAT_COUNT_LSB +: PSPC_CNT_W]             = periodCount;
  end

  always_comb
  begin
    readMux = '0;
    if (avsReq.address == PSPC_ADDR_TIMING)
    begin
      readMux[PSPC_REG_W-1:0] = cur.timing;
    end
    else if (avsReq.address == PSPC_ADDR_MODE)
    begin
      readMux[PSPC_REG_W-1:0] = cur.mode;
    end
    else if (avsReq.address == PSPC_ADDR_STATUS)
    begin
      readMux = statusWord;
    end
    else
    begin
      readMux = '0;
    end
  end

  always_comb
  begin
    next_cur = cur;

    // one wait state: data is latched at the first edge, released at the second
    next_cur.ack = busReq & ~cur.ack;
    if (busReq && !cur.ack)
    begin
      next_cur.readdata = avsReq.read ? readMux : '0;
    end

    if (writeTake)
    begin
      if (avsReq.address == PSPC_ADDR_TIMING)
      begin
        next_cur.timing = wrTiming;
      end
      else if (avsReq.address == PSPC_ADDR_MODE)
      begin
        next_cur.mode = wrMode;
      end
    end

    // an event in the same cycle as its clear still leaves the flag set
    next_cur.freqChangeError = freqErrSet | (cur.freqChangeError & ~freqErrClear);

    if (!cur.mode.generatorEnable)
    begin
      next_cur.phase = PSPC_ST_IDLE;
    end
    else
    begin
      case (cur.phase)
        PSPC_ST_IDLE,
        PSPC_ST_REST:
        begin
          if (periodStart)
          begin
            next_cur.sampledFeedback = feedback;
            if (!cur.mode.outputModeSelect)
            begin
              next_cur.phase       = feedback ? PSPC_ST_PULSE : PSPC_ST_REST;
              next_cur.skippedLast = !feedback;
            end
            else if (feedback || (minCycles != '0))
            begin
              next_cur.phase       = PSPC_ST_PULSE;
              next_cur.skippedLast = 1'b0;
            end
            else
            begin
              next_cur.phase       = PSPC_ST_REST;
              next_cur.skippedLast = 1'b1;
            end
          end
        end
        PSPC_ST_PULSE:
        begin
          if (!cur.mode.outputModeSelect)
          begin
            // comparator is not looked at until the fixed width has run out
            if (periodCount >= fixedCycles)
            begin
              next_cur.phase = PSPC_ST_REST;
            end
          end
          else if (periodCount >= maxCycles)
          begin
            next_cur.phase = PSPC_ST_REST;
          end
          else if (!feedback && (periodCount >= minCycles))
          begin
            next_cur.phase = PSPC_ST_REST;
          end
        end
        default:
        begin
          next_cur.phase = PSPC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur                 <= '0;
      cur.timing          <= PSPC_TIMING_RESET;
      cur.mode            <= PSPC_MODE_RESET;
      cur.phase           <= PSPC_ST_IDLE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // pins follow the next phase so they line up with the state register
  assign pulseActive = (next_cur.phase == PSPC_ST_PULSE);

  // slope window spans the period up to the maximum duty, a ramp reset marker
  assign slopeActive = running && (periodCount < maxCycles);

  // pins stay released until the generator is enabled
  assign firstDrive   = cur.mode.generatorEnable;
  assign secondDrive  = cur.mode.generatorEnable &&
                        (cur.mode.outputCountSelect || cur.mode.slopeCompEnable);
  assign secondActive = cur.mode.outputCountSelect ? pulseActive : slopeActive;

  pspc_output_stage u_first_stage
  (
    .clock    (clock),
    .rst_b    (rst_b),
    .drive    (firstDrive),
    .active   (pulseActive),
    .polarity (cur.mode.firstOutputPolarity),
    .pin      (firstPulseOutput)
  );

  pspc_output_stage u_second_stage
  (
    .clock    (clock),
    .rst_b    (rst_b),
    .drive    (secondDrive),
    .active   (secondActive),
    .polarity (cur.mode.secondOutputPolarity),
    .pin      (secondPulseOutput)
  );

endmodule : pspc_controller

// ===== verilog/pspc_output_stage.sv
`timescale 1ns/10ps

module pspc_output_stage
  import pspc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic drive,
  input  wire logic active,
  input  wire logic polarity,
  output pspc_pin_t pin
);

  pspc_pin_t cur;
  pspc_pin_t next_cur;

  // a released pin shows low on its output so nothing floats inside the chip
  always_comb
  begin
    next_cur     = cur;
    next_cur.oe  = drive;
    next_cur.out = drive ? (active ^ polarity) : 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign pin = cur;

endmodule : pspc_output_stage

// ===== verilog/pspc_period_timer.sv
`timescale 1ns/10ps

module pspc_period_timer
  import pspc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire logic                  run,
  input  wire logic [1:0]            frequencySelect,
  output logic      [PSPC_CNT_W-1:0] count,
  output logic                       running,
  output logic                       periodStart
);

  typedef struct packed
  {
    logic [PSPC_CNT_W-1:0] count;
    logic                  running;
  } pspc_timer_t;

  pspc_timer_t           cur;
  pspc_timer_t           next_cur;
  logic [PSPC_CNT_W-1:0] periodLast;

  assign periodLast = PSPC_CNT_W'((PSPC_PERIOD_MAX >> frequencySelect) - 8'h01);

  always_comb
  begin
    next_cur         = cur;
    next_cur.running = run;
    if (!run || !cur.running)
    begin
      next_cur.count = '0;
    end
    else if (cur.count >= periodLast)
    begin
      next_cur.count = '0;
    end
    else
    begin
      next_cur.count = cur.count + PSPC_CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign count       = cur.count;
  assign running     = cur.running;
  assign periodStart = cur.running && (cur.count == '0);

endmodule : pspc_period_timer

// ===== verilog/pspc_pkg.sv
package pspc_pkg;

  // register byte offsets on the Avalon-MM slave
  localparam logic [3:0]  PSPC_ADDR_TIMING     = 4'h0;
  localparam logic [3:0]  PSPC_ADDR_MODE       = 4'h4;
  localparam logic [3:0]  PSPC_ADDR_STATUS     = 4'h8;
  localparam int          PSPC_LANE0           = 0;
  localparam int          PSPC_REG_W           = 8;

  // status word bit positions
  localparam int          PSPC_STAT_PULSE      = 0;
  localparam int          PSPC_STAT_FEEDBACK   = 1;
  localparam int          PSPC_STAT_RUNNING    = 2;
  localparam int          PSPC_STAT_SKIPPED    = 3;
  localparam int          PSPC_STAT_FREQ_ERR   = 4;
  localparam int          PSPC_STAT_COUNT_LSB  = 8;

  // period counter: code 00 gives the longest period of 128 clocks
  localparam int          PSPC_CNT_W           = 7;
  localparam logic [7:0]  PSPC_PERIOD_MAX      = 8'h80;
  localparam logic [1:0]  PSPC_DUTY_SHIFT_MAX  = 2'h3;
  localparam int          PSPC_NIBBLE          = 4;

  // duty limits in sixteenths of a period, one nibble per field code
  localparam logic [15:0] PSPC_MIN_DUTY_TBL    = 16'h6420;
  localparam logic [15:0] PSPC_MAX_DUTY_TBL    = 16'hfca8;
  localparam logic [15:0] PSPC_FIXED_DUTY_TBL  = 16'hc864;

  typedef struct packed
  {
    logic [1:0] frequencySelect;
    logic [1:0] minDutyField;
    logic [1:0] maxDutyField;
    logic [1:0] fixedDutyField;
  } pspc_timing_t;

  typedef struct packed
  {
    logic generatorEnable;
    logic spare;
    logic secondOutputPolarity;
    logic firstOutputPolarity;
    logic outputCountSelect;
    logic slopeCompEnable;
    logic outputModeSelect;
    logic inputCountSelect;
  } pspc_mode_t;

  localparam pspc_timing_t PSPC_TIMING_RESET = 8'h00;
  localparam pspc_mode_t   PSPC_MODE_RESET   = 8'h00;

  typedef enum logic [1:0]
  {
    PSPC_ST_IDLE  = 2'b00,
    PSPC_ST_PULSE = 2'b01,
    PSPC_ST_REST  = 2'b11
  } pspc_state_t;

  typedef struct packed
  {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } pspc_avs_req_t;

  typedef struct packed
  {
    logic [31:0] readdata;
    logic        waitrequest;
  } pspc_avs_rsp_t;

  typedef struct packed
  {
    logic out;
    logic oe;
  } pspc_pin_t;

endpackage : pspc_pkg
